// ---- hw/gpm_pin_mux.sv ----
// function mux, pulls and read path for general-purpose pins 1 and 2
`timescale 1ns/100ps
`default_nettype none

module gpm_pin_mux (
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst,
  // register port
  input  wire logic [31:0]                  addr,
  input  wire logic [31:0]                  wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic      [31:0]                  rdata,
  // gpio controller, bit 0 pin1, bit 1 pin2
  input  wire logic [1:0]                   gpio_out,
  input  wire logic [1:0]                   gpio_dir,
  output logic      [1:0]                   gpio_in,
  // pwm channels 0 and 1
  input  wire logic [1:0]                   pwm_ch,
  // system control block
  input  wire logic                         debug_access_en,
  // lin master / slave and spi master
  input  wire logic                         lin_master_txd,
  output logic                              lin_master_rxd,
  input  wire logic                         lin_slave_txd,
  input  wire logic                         lin_slave_rx_flt2,
  input  wire logic                         lin_master_rx_flt2,
  input  wire logic                         lin_slave_rx_flt1,
  input  wire logic                         lin_slave_rx_flt_in,
  input  wire logic                         spi_ss,
  // debug signal groups
  input  wire logic [gpm_pkg::PMU_W-1:0]    pmu_bit0,
  input  wire logic                         cp_clk_4m,
  input  wire logic [gpm_pkg::CRG_W-1:0]    crg_dbg,
  input  wire logic                         adc_sync_rcvd0,
  input  wire logic [gpm_pkg::LIN_W-1:0]    lin_dbg,
  input  wire logic [gpm_pkg::BOR_W-1:0]    bor_dbg,
  input  wire logic [gpm_pkg::VBAT_W-1:0]   vbat_dbg,
  input  wire logic [gpm_pkg::BST_W-1:0]    buck_state,
  input  wire logic [gpm_pkg::BFC_W-1:0]    buck_fine,
  input  wire logic [gpm_pkg::BSTAT_W-1:0]  buck_stat,
  input  wire logic [gpm_pkg::DTB_W-1:0]    buck_dtb,
  input  wire logic                         lin_slave_phy_txd,
  input  wire logic                         lin_master_phy_txd,
  // pin 1 pad
  input  wire logic                         pad1_in,
  output logic                              pad1_out,
  output logic                              pad1_oe_n,
  output logic                              pad1_pu_en,
  output logic                              pad1_pd_en,
  output logic                              pad1_ie,
  // pin 2 pad
  input  wire logic                         pad2_in,
  output logic                              pad2_out,
  output logic                              pad2_oe_n,
  output logic                              pad2_pu_en,
  output logic                              pad2_pd_en,
  output logic                              pad2_ie
);

  // =====================================
  // control registers
  logic [5:0]            sel_ff;     // debug selector
  logic [1:0]            rd_en_ff;   // read path on, per pin
  logic [1:0]            pd_on_ff;   // pull-down on, per pin
  logic [1:0]            pu_off_ff;  // pull-up off (active low enable)
  gpm_pkg::gpm_p1_mode_t p1_mode_ff; // pin 1 function
  gpm_pkg::gpm_p2_mode_t p2_mode_ff; // pin 2 function

  // address decode
  logic hit1;
  logic hit2;
  assign hit1 = (addr == gpm_pkg::PIN1_CTRL_ADDR);
  assign hit2 = (addr == gpm_pkg::PIN2_CTRL_ADDR);

  // pin 1 register write
  always_ff @(posedge clock) begin
    if (rst) begin
      sel_ff       <= gpm_pkg::SEL_RST;
      p1_mode_ff   <= gpm_pkg::P1_GPIO;
    end else if (wr && hit1) begin
      sel_ff       <= wdata[gpm_pkg::SEL_LO +: gpm_pkg::SEL_W];
      p1_mode_ff   <= gpm_pkg::gpm_p1_mode_t'(wdata[gpm_pkg::MODE_LO +: gpm_pkg::MODE_W]);
    end
  end

  // pin 2 register write
  always_ff @(posedge clock) begin
    if (rst) begin
      p2_mode_ff <= gpm_pkg::P2_GPIO;
    end else if (wr && hit2) begin
      p2_mode_ff <= gpm_pkg::gpm_p2_mode_t'(wdata[gpm_pkg::MODE_LO +: gpm_pkg::MODE_W]);
    end
  end

  // shared pad control bits, one lane per pin
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_en_ff  <= {2{gpm_pkg::RD_RST}};
      pd_on_ff  <= {2{gpm_pkg::PD_RST}};
      pu_off_ff <= {2{gpm_pkg::PU_OFF_RST}};
    end else begin
      if (wr && hit1) begin
        rd_en_ff[0]  <= wdata[gpm_pkg::RD_BIT];
        pd_on_ff[0]  <= wdata[gpm_pkg::PD_BIT];
        pu_off_ff[0] <= wdata[gpm_pkg::PU_BIT];
      end
      if (wr && hit2) begin
        rd_en_ff[1]  <= wdata[gpm_pkg::RD_BIT];
        pd_on_ff[1]  <= wdata[gpm_pkg::PD_BIT];
        pu_off_ff[1] <= wdata[gpm_pkg::PU_BIT];
      end
    end
  end

  // =====================================
  // read-back, one cycle after the strobe
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h0000_0000; // unmapped and undefined bits read 0
    if (hit1) begin
      nxt_rdata[gpm_pkg::SEL_LO +: gpm_pkg::SEL_W]   = sel_ff;
      nxt_rdata[gpm_pkg::RD_BIT]                     = rd_en_ff[0];
      nxt_rdata[gpm_pkg::PD_BIT]                     = pd_on_ff[0];
      nxt_rdata[gpm_pkg::PU_BIT]                     = pu_off_ff[0];
      nxt_rdata[gpm_pkg::MODE_LO +: gpm_pkg::MODE_W] = p1_mode_ff;
    end else if (hit2) begin
      nxt_rdata[gpm_pkg::RD_BIT]                     = rd_en_ff[1];
      nxt_rdata[gpm_pkg::PD_BIT]                     = pd_on_ff[1];
      nxt_rdata[gpm_pkg::PU_BIT]                     = pu_off_ff[1];
      nxt_rdata[gpm_pkg::MODE_LO +: gpm_pkg::MODE_W] = p2_mode_ff;
    end
  end

  // read data register, zero outside a read answer
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      rdata <= nxt_rdata;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // =====================================
  // debug signal table, unlisted codes stay low
  logic [gpm_pkg::DBG_N-1:0] dbg_tbl;
  logic                      dbg_bit;
  always_comb begin
    dbg_tbl = '0;
    dbg_tbl[gpm_pkg::DBG_PMU +: gpm_pkg::PMU_W]     = pmu_bit0;
    dbg_tbl[gpm_pkg::DBG_CP]                        = cp_clk_4m;
    dbg_tbl[gpm_pkg::DBG_CRG +: gpm_pkg::CRG_W]     = crg_dbg;
    dbg_tbl[gpm_pkg::DBG_ADC]                       = adc_sync_rcvd0;
    dbg_tbl[gpm_pkg::DBG_LIN +: gpm_pkg::LIN_W]     = lin_dbg;
    dbg_tbl[gpm_pkg::DBG_BOR +: gpm_pkg::BOR_W]     = bor_dbg;
    dbg_tbl[gpm_pkg::DBG_VBAT +: gpm_pkg::VBAT_W]   = vbat_dbg;
    dbg_tbl[gpm_pkg::DBG_BST +: gpm_pkg::BST_W]     = buck_state;
    dbg_tbl[gpm_pkg::DBG_BFC +: gpm_pkg::BFC_W]     = buck_fine;
    dbg_tbl[gpm_pkg::DBG_BSTAT +: gpm_pkg::BSTAT_W] = buck_stat;
    dbg_tbl[gpm_pkg::DBG_DTB +: gpm_pkg::DTB_W]     = buck_dtb;
    dbg_tbl[gpm_pkg::DBG_SPHY]                      = lin_slave_phy_txd;
    dbg_tbl[gpm_pkg::DBG_MPHY]                      = lin_master_phy_txd;
  end
  assign dbg_bit = dbg_tbl[sel_ff];

  // =====================================
  // pin 1 routing
  logic nxt_p1_out;
  logic nxt_p1_oe_n;
  logic nxt_lin_master_rxd;
  always_comb begin
    nxt_p1_out   = 1'b0;
    nxt_p1_oe_n  = 1'b0;
    nxt_lin_master_rxd = gpm_pkg::RXD_IDLE; // recessive when not routed
    case (p1_mode_ff)
      gpm_pkg::P1_GPIO: begin
        nxt_p1_out  = gpio_out[0];
        nxt_p1_oe_n = ~gpio_dir[0];
      end
      gpm_pkg::P1_PWM: begin
        nxt_p1_out = pwm_ch[0];
      end
      gpm_pkg::P1_TMUX: begin
        nxt_p1_out = dbg_bit & debug_access_en;
      end
      gpm_pkg::P1_LIN_EXT: begin
        nxt_p1_oe_n  = 1'b1;
        nxt_lin_master_rxd = pad1_in;
      end
      gpm_pkg::P1_LIN_SW: begin
        nxt_p1_oe_n  = lin_master_txd; // pull low only for dominant
        nxt_lin_master_rxd = pad1_in;
      end
      gpm_pkg::P1_MON_S: begin
        nxt_p1_out = lin_slave_rx_flt2;
      end
      gpm_pkg::P1_MON_M: begin
        nxt_p1_out = lin_master_rx_flt2;
      end
      default: begin
        nxt_p1_out = 1'b0;
      end
    endcase
  end

  // =====================================
  // pin 2 routing
  logic nxt_p2_out;
  logic nxt_p2_oe_n;
  always_comb begin
    nxt_p2_out  = 1'b0;
    nxt_p2_oe_n = 1'b0;
    case (p2_mode_ff)
      gpm_pkg::P2_GPIO: begin
        nxt_p2_out  = gpio_out[1];
        nxt_p2_oe_n = ~gpio_dir[1];
      end
      gpm_pkg::P2_PWM: begin
        nxt_p2_out = pwm_ch[1];
      end
      gpm_pkg::P2_TMUX: begin
        nxt_p2_out = lin_slave_txd & debug_access_en;
      end
      gpm_pkg::P2_LIN_MASTER_TX: begin
        nxt_p2_out = lin_master_txd;
      end
      gpm_pkg::P2_SPI_SS: begin
        nxt_p2_out = spi_ss;
      end
      gpm_pkg::P2_MON_G1: begin
        nxt_p2_out = lin_slave_rx_flt1;
      end
      gpm_pkg::P2_MON_IN: begin
        nxt_p2_out = lin_slave_rx_flt_in;
      end
      default: begin
        nxt_p2_out = 1'b0;
      end
    endcase
  end

  // =====================================
  // registered pad and peripheral outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      pad1_out  <= 1'b0;
      pad1_oe_n <= 1'b1;
      pad2_out  <= 1'b0;
      pad2_oe_n <= 1'b1;
      lin_master_rxd  <= gpm_pkg::RXD_IDLE;
    end else begin
      pad1_out  <= nxt_p1_out;
      pad1_oe_n <= nxt_p1_oe_n;
      pad2_out  <= nxt_p2_out;
      pad2_oe_n <= nxt_p2_oe_n;
      lin_master_rxd  <= nxt_lin_master_rxd;
    end
  end

  // read path toward the gpio controller
  always_ff @(posedge clock) begin
    if (rst) begin
      gpio_in <= 2'h0;
    end else begin
      gpio_in <= {pad2_in, pad1_in} & rd_en_ff;
    end
  end

  // pulls and input enables straight from the registers
  assign pad1_pu_en = ~pu_off_ff[0];
  assign pad2_pu_en = ~pu_off_ff[1];
  assign pad1_pd_en = pd_on_ff[0];
  assign pad2_pd_en = pd_on_ff[1];
  assign pad1_ie    = rd_en_ff[0];
  assign pad2_ie    = rd_en_ff[1];

  // =====================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_sel_rd;
    (rd && hit1) |=> rdata[gpm_pkg::SEL_LO +: gpm_pkg::SEL_W] == $past(sel_ff);
  endproperty
  a_sel_rd: assert property (p_sel_rd) else $error("selector readback wrong");

  property p_zero_bits;
    rd |=> (rdata[31:30] == 2'h0) && (rdata[23:6] == 18'h0);
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("undefined bits not zero");

  property p_rd_gate;
    !rd_en_ff[0] |=> !gpio_in[0];
  endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("read path not gated");

  property p_pd_wr;
    (wr && hit1) |=> pad1_pd_en == $past(wdata[gpm_pkg::PD_BIT]);
  endproperty
  a_pd_wr: assert property (p_pd_wr) else $error("pull-down not taken");

  property p_pu_wr;
    (wr && hit1) |=> pad1_pu_en == !$past(wdata[gpm_pkg::PU_BIT]);
  endproperty
  a_pu_wr: assert property (p_pu_wr) else $error("pull-up polarity wrong");

  property p_gpio;
    (p1_mode_ff == gpm_pkg::P1_GPIO) |=>
      (pad1_out == $past(gpio_out[0])) && (pad1_oe_n == !$past(gpio_dir[0]));
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio mode routing wrong");

  property p_pwm;
    (p1_mode_ff == gpm_pkg::P1_PWM) |=> !pad1_oe_n && pad1_out == $past(pwm_ch[0]);
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm mode routing wrong");

  property p_tmux_gate;
    (p1_mode_ff == gpm_pkg::P1_TMUX && !debug_access_en) |=> !pad1_out;
  endproperty
  a_tmux_gate: assert property (p_tmux_gate) else $error("testmux leaked");

  property p_lin_ext;
    (p1_mode_ff == gpm_pkg::P1_LIN_EXT) |=> pad1_oe_n && lin_master_rxd == $past(pad1_in);
  endproperty
  a_lin_ext: assert property (p_lin_ext) else $error("lin input mode wrong");

  property p_lin_sw;
    (p1_mode_ff == gpm_pkg::P1_LIN_SW) |=> !pad1_out && pad1_oe_n == $past(lin_master_txd)
      && lin_master_rxd == $past(pad1_in);
  endproperty
  a_lin_sw: assert property (p_lin_sw) else $error("open-drain lin wrong");

  property p_mon_m;
    (p1_mode_ff == gpm_pkg::P1_MON_M) |=> pad1_out == $past(lin_master_rx_flt2);
  endproperty
  a_mon_m: assert property (p_mon_m) else $error("master monitor wrong");

  property p_mon_s;
    (p1_mode_ff == gpm_pkg::P1_MON_S) |=> !pad1_oe_n && pad1_out == $past(lin_slave_rx_flt2);
  endproperty
  a_mon_s: assert property (p_mon_s) else $error("slave monitor wrong");

  property p_undef;
    (p1_mode_ff == gpm_pkg::P1_TMUX && sel_ff > 6'h33 && sel_ff != 6'h37
      && sel_ff != 6'h3b) |=> !pad1_out;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined code not low");

  property p_ss;
    (p2_mode_ff == gpm_pkg::P2_SPI_SS) |=> pad2_out == $past(spi_ss);
  endproperty
  a_ss: assert property (p_ss) else $error("slave select not routed");

endmodule

`default_nettype wire

// ---- shared/gpm_pkg.sv ----
// constants for the pin 1 / pin 2 function mux
`default_nettype none

package gpm_pkg;
  // =====================================
  // register map (byte addresses)
  localparam logic [31:0] PIN1_CTRL_ADDR = 32'h5001_2000;
  localparam logic [31:0] PIN2_CTRL_ADDR = 32'h5001_2004;

  // =====================================
  // field positions
  localparam int SEL_LO  = 24;
  localparam int SEL_W   = 6;
  localparam int RD_BIT  = 5;
  localparam int PD_BIT  = 4;
  localparam int PU_BIT  = 3;
  localparam int MODE_LO = 0;
  localparam int MODE_W  = 3;

  // =====================================
  // reset values
  localparam logic [5:0] SEL_RST    = 6'h00;
  localparam logic       RD_RST     = 1'h0;
  localparam logic       PD_RST     = 1'h0;
  localparam logic       PU_OFF_RST = 1'h1;
  localparam logic       RXD_IDLE   = 1'h1;

  // =====================================
  // pin 1 functions
  typedef enum logic [2:0] {
    P1_GPIO    = 3'h0,
    P1_PWM     = 3'h1,
    P1_TMUX    = 3'h2,
    P1_LIN_EXT = 3'h3,
    P1_LIN_SW  = 3'h4,
    P1_MON_S   = 3'h5,
    P1_MON_M   = 3'h6
  } gpm_p1_mode_t;

  // pin 2 functions
  typedef enum logic [2:0] {
    P2_GPIO    = 3'h0,
    P2_PWM     = 3'h1,
    P2_TMUX    = 3'h2,
    P2_LIN_MASTER_TX = 3'h3,
    P2_SPI_SS  = 3'h4,
    P2_MON_G1  = 3'h5,
    P2_MON_IN  = 3'h6
  } gpm_p2_mode_t;

  // =====================================
  // debug selector code bases and group widths
  localparam int DBG_N     = 64;
  localparam int DBG_PMU   = 'h00;
  localparam int PMU_W     = 3;
  localparam int DBG_CP    = 'h03;
  localparam int DBG_CRG   = 'h04;
  localparam int CRG_W     = 10;
  localparam int DBG_ADC   = 'h0e;
  localparam int DBG_LIN   = 'h0f;
  localparam int LIN_W     = 4;
  localparam int DBG_BOR   = 'h13;
  localparam int BOR_W     = 8;
  localparam int DBG_VBAT  = 'h1b;
  localparam int VBAT_W    = 6;
  localparam int DBG_BST   = 'h21;
  localparam int BST_W     = 5;
  localparam int DBG_BFC   = 'h26;
  localparam int BFC_W     = 7;
  localparam int DBG_BSTAT = 'h2d;
  localparam int BSTAT_W   = 4;
  localparam int DBG_DTB   = 'h31;
  localparam int DTB_W     = 3;
  localparam int DBG_SPHY  = 'h37;
  localparam int DBG_MPHY  = 'h3b;
endpackage

`default_nettype wire

// ---- tb/gpio_pin_function_mux_tb_top.sv ----
// self-checking bench for the pin 1 / pin 2 function mux
`timescale 1ns/100ps
`default_nettype none

module gpio_pin_function_mux_tb_top;
  // =====================================
  // stimulus, observed signals, scoreboard
  localparam logic [31:0] P1 = gpm_pkg::PIN1_CTRL_ADDR;
  localparam logic [31:0] P2 = gpm_pkg::PIN2_CTRL_ADDR;
  logic        clock  = 1'b0;   // 125 MHz system clock
  logic        rst    = 1'b1;   // synchronous reset
  logic [31:0] addr   = 32'h0;  // register port
  logic [31:0] wdata  = 32'h0;
  logic        wr     = 1'b0;
  logic        rd     = 1'b0;
  logic [15:0] rv     = 16'h0;  // packed peripheral levels
  logic [63:0] dbg    = 64'h0;  // debug sources, bit n is selector code n
  logic        dbg_en = 1'b0;   // debug access from system control
  logic        ext_en = 1'b0;   // outside driver on pin 1
  logic [31:0] rdata;
  logic [1:0]  gpio_in;
  logic        lin_master_rxd;
  logic        pad1_in, pad1_out, pad1_oe_n, pad1_pu_en, pad1_pd_en, pad1_ie;
  logic        pad2_in, pad2_out, pad2_oe_n, pad2_pu_en, pad2_pd_en, pad2_ie;
  int          n_fail = 0;
  int          check_count = 0;
  logic [31:0] exp_q[$];        // expected values, oldest first
  int          kind_q[$];       // which output each note is about
  event        look;

  always #4 clock = ~clock;

  // =====================================
  // design and pad partners
  gpm_pin_mux gpm_pin_mux_i (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .gpio_out(rv[1:0]), .gpio_dir(rv[3:2]), .gpio_in(gpio_in), .pwm_ch(rv[5:4]),
    .debug_access_en(dbg_en), .lin_master_txd(rv[6]), .lin_master_rxd(lin_master_rxd), .lin_slave_txd(rv[7]),
    .lin_slave_rx_flt2(rv[8]), .lin_master_rx_flt2(rv[9]), .lin_slave_rx_flt1(rv[10]),
    .lin_slave_rx_flt_in(rv[11]), .spi_ss(rv[12]), .pmu_bit0(dbg[2:0]), .cp_clk_4m(dbg[3]),
    .crg_dbg(dbg[13:4]), .adc_sync_rcvd0(dbg[14]), .lin_dbg(dbg[18:15]),
    .bor_dbg(dbg[26:19]), .vbat_dbg(dbg[32:27]), .buck_state(dbg[37:33]),
    .buck_fine(dbg[44:38]), .buck_stat(dbg[48:45]), .buck_dtb(dbg[51:49]),
    .lin_slave_phy_txd(dbg[55]), .lin_master_phy_txd(dbg[59]),
    .pad1_in(pad1_in), .pad1_out(pad1_out), .pad1_oe_n(pad1_oe_n), .pad1_pu_en(pad1_pu_en),
    .pad1_pd_en(pad1_pd_en), .pad1_ie(pad1_ie),
    .pad2_in(pad2_in), .pad2_out(pad2_out), .pad2_oe_n(pad2_oe_n), .pad2_pu_en(pad2_pu_en),
    .pad2_pd_en(pad2_pd_en), .pad2_ie(pad2_ie)
  );
  gpm_pad_partner gpm_pad_partner_i (
    .clock(clock), .pad_out(pad1_out), .pad_oe_n(pad1_oe_n), .pu_en(pad1_pu_en),
    .pd_en(pad1_pd_en), .ext_en(ext_en), .ext_val(rv[13]), .pad_in(pad1_in)
  );
  gpm_pad_partner gpm_pad_partner_2_i (
    .clock(clock), .pad_out(pad2_out), .pad_oe_n(pad2_oe_n), .pu_en(pad2_pu_en),
    .pd_en(pad2_pd_en), .ext_en(1'b0), .ext_val(1'b1), .pad_in(pad2_in)
  );

  // =====================================
  // expectations worked out from the peripheral levels
  function automatic logic [1:0] exp_p1(input logic [2:0] m);  // {oe_n, out}
    case (m)
      3'h0: return {~rv[2], rv[0]};
      3'h1: return {1'b0, rv[4]};
      3'h2: return {1'b0, dbg_en & dbg[0]};
      3'h4: return {rv[6], 1'b0};
      3'h5: return {1'b0, rv[8]};
      3'h6: return {1'b0, rv[9]};
      default: return 2'b00;
    endcase
  endfunction

  function automatic logic [1:0] exp_p2(input logic [2:0] m);
    case (m)
      3'h0: return {~rv[3], rv[1]};
      3'h1: return {1'b0, rv[5]};
      3'h2: return {1'b0, dbg_en & rv[7]};
      3'h3: return {1'b0, rv[6]};
      3'h4: return {1'b0, rv[12]};
      3'h5: return {1'b0, rv[10]};
      3'h6: return {1'b0, rv[11]};
      default: return 2'b00;
    endcase
  endfunction

  // selector codes that route a real source
  function automatic logic is_def(input logic [5:0] c);
    return (c <= 6'h33) || (c == 6'h37) || (c == 6'h3b);
  endfunction

  // pick the observed output for a note kind
  function automatic logic [31:0] observe(input int kind);
    case (kind)
      0: return rdata;
      1: return {30'h0, pad1_oe_n, pad1_out};
      2: return {30'h0, pad2_oe_n, pad2_out};
      3: return {29'h0, pad1_pu_en, pad1_pd_en, pad1_ie};
      4: return {29'h0, pad2_pu_en, pad2_pd_en, pad2_ie};
      5: return {29'h0, lin_master_rxd, gpio_in};
      default: return {31'h0, pad1_oe_n};
    endcase
  endfunction

  // =====================================
  // scoreboard tasks
  task automatic expect_val(input int kind, input logic [31:0] v);
    exp_q.push_back(v);
    kind_q.push_back(kind);
    -> look;
  endtask

  // count one comparison and report a mismatch
  task automatic report(input int kind, input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t kind %0d got %h exp %h", $time, kind, g, e);
    end
  endtask

  // register read data, looked at while it stands
  task automatic cmp_rdata(input logic [31:0] e);
    report(0, rdata, e);
  endtask

  // pad drive: output enable and data of one pin
  task automatic cmp_drive(input int kind, input logic [31:0] e);
    report(kind, observe(kind), e);
  endtask

  // pulls and input enable of one pin
  task automatic cmp_pull(input int kind, input logic [31:0] e);
    report(kind, observe(kind), e);
  endtask

  // receive paths toward the gpio and lin controllers
  task automatic cmp_rx(input logic [31:0] e);
    report(5, observe(5), e);
  endtask

  // watcher: takes the oldest notes once the outputs have settled
  initial begin
    int          k;
    logic [31:0] e;
    forever begin
      @(look);
      #1;
      while (kind_q.size() > 0) begin
        k = kind_q.pop_front();
        e = exp_q.pop_front();
        case (k)
          0: cmp_rdata(e);
          3, 4: cmp_pull(k, e);
          5: cmp_rx(e);
          default: cmp_drive(k, e);
        endcase
      end
    end
  end

  // =====================================
  // register bus and timing tasks
  task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    expect_val(0, e);
  endtask

  // let one-cycle routing latency and the pad loop land
  task automatic settle();
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic give_verdict();
    $display("counts: %0d checks, %0d mismatches", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog well beyond the expected run of about 955 cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    give_verdict();
  end

  // =====================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic [2:0]  m;
    void'($urandom(18122));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    reg_rd(P1, 32'h8);
    reg_rd(P2, 32'h8);
    settle();
    expect_val(1, 32'h2);
    expect_val(3, 32'h0);
    expect_val(5, 32'h4);
    $display("test reset done");
    // field masks, unmapped and unaligned addresses
    d = $urandom;
    reg_wr(P1, d);
    reg_rd(P1, d & 32'h3f00_003f);
    reg_wr(P2, ~d);
    reg_rd(P2, ~d & 32'h3f);
    reg_wr(32'h5001_2001, 32'hffff_ffff);
    reg_rd(32'h5001_2001, 32'h0);
    reg_rd(P1, d & 32'h3f00_003f);
    $display("test registers done");
    // pulls and read path in general-purpose mode, pads released
    for (int b = 0; b < 8; b++) begin
      @(posedge clock);
      rv <= 16'h0;
      reg_wr(P1, {26'h0, b[2:0], 3'h0});
      reg_wr(P2, {26'h0, b[2:0], 3'h0});
      settle();
      expect_val(3, {29'h0, ~b[0], b[1], b[2]});
      expect_val(4, {29'h0, ~b[0], b[1], b[2]});
      if (b[0] == b[1]) begin
        expect_val(5, {29'h0, 1'b1, {2{b[2] & ~b[0]}}});
      end
    end
    $display("test pulls done");
    // every function of both pins with random peripheral levels
    for (int it = 0; it < 32; it++) begin
      m = it[2:0];
      @(posedge clock);
      rv <= 16'($urandom);
      dbg <= {$urandom, $urandom};
      dbg_en <= 1'($urandom);
      ext_en <= 1'b1;
      reg_wr(P1, {26'h0, 3'b001, m});
      reg_wr(P2, {26'h0, 3'b001, m});
      settle();
      if (m == 3'h3) begin
        expect_val(6, 32'h1);
      end else begin
        expect_val(1, {30'h0, exp_p1(m)});
      end
      expect_val(2, {30'h0, exp_p2(m)});
      expect_val(5, {29'h0, (m == 3'h3) ? rv[13] : (m == 3'h4) ? rv[6] & rv[13] : 1'b1, 2'b00});
    end
    $display("test modes done");
    // debug selector sweep with a one-hot source and its complement
    for (int c = 0; c < 64; c++) begin
      for (int t = 0; t < 2; t++) begin
        @(posedge clock);
        dbg <= (t == 0) ? (64'h1 << c) : ~(64'h1 << c);
        dbg_en <= 1'b1;
        reg_wr(P1, {2'b00, 6'(c), 24'h00_000a});
        settle();
        expect_val(1, {31'h0, is_def(6'(c)) & (t == 0)});
      end
    end
    $display("test debug selector done");
    // reset in mid-run brings the registers back
    reg_wr(P1, 32'hffff_ffff);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    reg_rd(P1, 32'h8);
    reg_rd(P2, 32'h8);
    $display("test second reset done");
    repeat (2) @(negedge clock);
    give_verdict();
  end
endmodule

`default_nettype wire

// ---- tb/gpm_pad_partner.sv ----
// outside-world model of one pad: pulls, an outside driver and a floating line
`timescale 1ns/100ps
`default_nettype none

module gpm_pad_partner (
  // clock for the floating pattern
  input  wire logic clock,
  // pad side of the mux
  input  wire logic pad_out,
  input  wire logic pad_oe_n,
  input  wire logic pu_en,
  input  wire logic pd_en,
  // outside open-drain style driver
  input  wire logic ext_en,
  input  wire logic ext_val,
  // level seen back by the mux
  output logic      pad_in
);
  logic float_ff;  // level of a line nobody drives or pulls

  initial float_ff = 1'b0;

  // an undriven, unpulled line flips every cycle so no stale level is seen
  always @(posedge clock) begin
    float_ff <= ~float_ff;
  end

  // resolve the wire: drivers wire-and, else pulls, else floating
  always_comb begin
    if (!pad_oe_n && ext_en) begin
      pad_in = pad_out & ext_val;
    end else if (!pad_oe_n) begin
      pad_in = pad_out;
    end else if (ext_en) begin
      pad_in = ext_val;
    end else if (pu_en) begin
      pad_in = 1'b1;
    end else if (pd_en) begin
      pad_in = 1'b0;
    end else begin
      pad_in = float_ff;
    end
  end
endmodule

`default_nettype wire
